// ### tb.sv
// Self-checking bench for the question/status watchdog over its register bus
`default_nettype none
module tb;
  import wdq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr, expected_response;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, fail_counter, fail_count_threshold, question_value;
  logic [1:0] bresp, rresp, r;
  int errors, n_tests, cyc, t0, t1, i;
  logic [7:0] ca [3] = '{8'h00, 8'h0C, 8'h10};
  logic [7:0] cv [3] = '{8'h5A, 8'h04, 8'h03};
  wdq_watchdog #(.TICK_CYCLES(8)) wdq_watchdog_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .expected_response(expected_response),
    .fail_counter(fail_counter), .fail_count_threshold(fail_count_threshold),
    .question_value(question_value), .irq(irq));
  wdq_mcu_model wdq_mcu_model_i (.question_value(question_value),
    .expected_response(expected_response));
  // Clock and free cycle count
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task hang;
    errors++;
    $display("Error wait expected done seen timeout");
    give_verdict;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    if (n == 50)
      hang;
    r = bresp;
    bready <= 1'b0;
  endtask
  // Bus read and masked compare
  task rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string s);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    if (n == 50)
      hang;
    r = rresp;
    rready <= 1'b0;
    chk(s, e, rdata & m);
  endtask
  // Clear pending interrupts, then wait for the next cycle-end interrupt
  task wait_end(output int t);
    int n;
    axw(8'h20, 32'h3F);
    for (n = 0; n < 8 && irq !== 1'b0; n++)
      @(posedge sys_clk);
    if (irq !== 1'b0)
      hang;
    for (n = 0; n < 300 && irq !== 1'b1; n++)
      @(posedge sys_clk);
    if (n == 300)
      hang;
    t = cyc;
  endtask
  // Main sequence
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, cyc, errors, n_tests} = '0;
    {awaddr, araddr, wdata, fail_counter} = '0;
    wstrb = 4'hF;
    fail_count_threshold = 4'h4;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("question port", 32'h0C, {28'h0, question_value});
    rc(8'h00, 32'h0A, 32'hFFFFFFFF, "qa config");
    chk("read rresp", 32'h0, {30'h0, r});
    rc(8'h04, 32'h0C, 32'hFFFFFFFF, "question");
    rc(8'h08, 32'hE0, 32'hFFFFFFFF, "flags reset");
    rc(8'h08, 32'h60, 32'hFFFFFFFF, "flags after read");
    @(posedge sys_clk);
    fail_counter <= 4'h4;
    rc(8'h08, 32'h80, 32'h80, "fail flag set");
    rc(8'h08, 32'h80, 32'h80, "fail flag kept");
    fail_counter <= 4'h0;
    $display("test reset values done");
    for (i = 0; i < 3; i++)
    begin
      axw(ca[i], {24'h0, cv[i]});
      chk("write bresp", 32'h0, {30'h0, r});
      rc(8'h08, 32'h10, 32'h10, "config change");
      rc(ca[i], {24'h0, cv[i]}, 32'hFFFFFFFF, "config readback");
    end
    axw(8'h0C, 32'h04);
    rc(8'h08, 32'h00, 32'h10, "same value write");
    axw(8'h28, 32'h1);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    rc(8'h28, 32'h0, 32'hFFFFFFFF, "unmapped rdata");
    chk("unmapped rresp", 32'h2, {30'h0, r});
    $display("test configuration done");
    axw(8'h24, 32'h03);
    axw(8'h14, 32'h0);
    wait_end(t0);
    wait_end(t1);
    chk("cycle period", 32'd72, 32'(t1 - t0));
    rc(8'h08, 32'h06, 32'h0F, "idle cycle");
    for (i = 0; i < 4; i++)
      axw(8'h18, {24'h0, expected_response});
    wait_end(t0);
    rc(8'h08, 32'h61, 32'hFF, "early answers");
    // Seed 1010b stepped once with the select-1 taps gives 0101b
    rc(8'h04, 32'h05, 32'hFF, "question step");
    chk("question port step", 32'h05, {28'h0, question_value});
    axw(8'h18, {24'h0, ~expected_response});
    rc(8'h08, 32'h40, 32'h60, "count after one");
    wait_end(t0);
    rc(8'h08, 32'h6E, 32'hFF, "wrong answer");
    wait_end(t0);
    rc(8'h08, 32'h66, 32'hFF, "tallies restart");
    $display("test mode 0 done");
    axw(8'h14, 32'h1);
    rc(8'h08, 32'h10, 32'h10, "mode change");
    wait_end(t0);
    rc(8'h08, 32'h22, 32'hEF, "mode 1 silent");
    axw(8'h18, {24'h0, expected_response});
    wait_end(t0);
    rc(8'h08, 32'h21, 32'hFF, "mode 1 early");
    $display("test mode 1 done");
    // Reseed in the reset state with select 2, then one clean cycle steps 0011b to 0111b
    axw(8'h14, 32'h3);
    axw(8'h00, 32'h23);
    rc(8'h00, 32'h23, 32'hFF, "reseed config");
    axw(8'h14, 32'h1);
    axw(8'h18, {24'h0, expected_response});
    wait_end(t0);
    rc(8'h04, 32'h07, 32'hFF, "question after reseed");
    $display("test reseed done");
    axw(8'h24, 32'h0);
    repeat (80) @(posedge sys_clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    rc(8'h1C, 32'h02, 32'h02, "irq status");
    axw(8'h20, 32'h3F);
    rc(8'h1C, 32'h0, 32'h3F, "irq cleared");
    $display("test interrupts done");
    give_verdict;
  end
endmodule
`default_nettype wire

// ### wdq_mcu_model.sv
// Microcontroller side model: forms the watchdog answer byte from the question
`default_nettype none
module wdq_mcu_model
  import wdq_pkg::*;
(
  input wire logic [3:0] question_value,
  output logic [7:0] expected_response
);
  timeunit 1ns;
  timeprecision 1ns;
  // Answer byte derived from the question just read, written later as the response
  assign expected_response = {~question_value, question_value};
endmodule
`default_nettype wire

// ### wdq_params.svh
// Register map, reset values, counter and tap constants and timing for the question/status watchdog
`ifndef WDQ_PARAMS_SVH
`define WDQ_PARAMS_SVH
`define WDQ_A_QACFG 8'h00
`define WDQ_A_QUEST 8'h04
`define WDQ_A_FLAGS 8'h08
`define WDQ_A_WIN1 8'h0C
`define WDQ_A_WIN2 8'h10
`define WDQ_A_CTRL 8'h14
`define WDQ_A_ANSWER 8'h18
`define WDQ_A_IRQST 8'h1C
`define WDQ_A_IRQCLR 8'h20
`define WDQ_A_IRQEN 8'h24
`define WDQ_RST_QACFG 8'h0A
`define WDQ_RST_QUEST 4'hC
`define WDQ_RST_WIN1 8'hFF
`define WDQ_RST_WIN2 5'h1F
`define WDQ_CNT_MODE0 2'h3
`define WDQ_CNT_MODE1 2'h1
`define WDQ_SEQ_MIN 3'h3
`define WDQ_FULL_ANS 3'h4
`define WDQ_TICK_NS 550000
`define WDQ_CLK_NS 20
`define WDQ_TAPS0 4'hC
`define WDQ_TAPS1 4'h9
`define WDQ_TAPS2 4'h6
`define WDQ_TAPS3 4'h3
`define WDQ_RESP_OK 2'h0
`define WDQ_RESP_ERR 2'h2
`endif

// ### wdq_pkg.sv
// Types shared by the question/status watchdog
`default_nettype none
package wdq_pkg;
  typedef struct packed {
    logic fc_dis;
    logic cfg_chg;
    logic wrong;
    logic seq;
    logic timeout;
    logic early;
  } wdq_flags_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] qa_cfg;
    logic [7:0] win1;
    logic [4:0] win2;
    logic mode;
    logic in_reset;
    logic [3:0] lfsr;
    logic [3:0] question;
    logic [1:0] answer_cnt;
    wdq_flags_type flags;
    logic [5:0] irq_stat;
    logic [5:0] irq_en;
    logic irq;
    logic [15:0] tick_cnt;
    logic tick;
    logic win2_phase;
    logic [7:0] win_cnt;
    logic [2:0] w1_answers;
    logic [2:0] cyc_answers;
    logic wrong_seen;
  } wdq_state_type;
endpackage
`default_nettype wire

// ### wdq_watchdog.sv
// Question generator, window timing and status flags of the question/answer watchdog
//
// Overview of operation
// - LFSR takes the 4-bit seed, default 1010b, while the device sits in reset.
// - Config holds answer-generation select bits 7-6, polynomial select bits 5-4, cleared.
// - Question reads in low nibble, starts at 1100b, upper nibble reads zero.
// - Fail-count flag sets at counter >= threshold; read clears only below; starts 1.
// - Two-bit answer counter moves per answer; starts 11b in mode 0, 01b in mode 1.
// - Changing either window length, question config or mode sets a read-cleared flag.
// - Cycle end sets read-cleared wrong-answer flag if any response was incorrect.
// - Mode 0 cycle end sets sequence flag if under 3 responses in first window.
// - Cycle end sets time-out flag: under 4 responses (mode 0), none (mode 1).
// - Early flag: 4 responses in first window (mode 0), one in close window (mode 1).
// - First window lasts (8-bit length plus one) times 0.55 ms.
// - Second window lasts (5-bit length plus one) times 0.55 ms.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`default_nettype none
`include "wdq_params.svh"
module wdq_watchdog
  import wdq_pkg::*;
#(
  parameter int TICK_CYCLES = `WDQ_TICK_NS / `WDQ_CLK_NS
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] expected_response,
  input wire logic [3:0] fail_counter,
  input wire logic [3:0] fail_count_threshold,
  output logic [3:0] question_value,
  output logic irq
);
  // Refuse a tick divider that the 16-bit counter cannot hold
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535)
  begin : g_tick_check
    $error("TICK_CYCLES out of range for the 16-bit tick counter");
  end

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  wdq_state_type s;
  wdq_state_type n;
  logic wr_go;
  logic rd_go;
  logic ans_go;
  logic cyc_end;
  logic [7:0] wd;

  // Handshakes and cycle boundary seen from the present state
  assign wr_go = s.awready && awvalid && wvalid;
  assign rd_go = s.arready && arvalid;
  assign wd = wdata[7:0];
  assign ans_go = wr_go && wstrb[0] && awaddr == `WDQ_A_ANSWER;
  assign cyc_end = !s.in_reset && s.tick && s.win2_phase && s.win_cnt == {3'h0, s.win2};

  // Next-state logic for the whole block
  always_comb
  begin
    wdq_flags_type set_f;
    wdq_flags_type clr_f;
    logic [5:0] irq_clr;
    logic fb;
    set_f = '0;
    clr_f = '0;
    irq_clr = '0;
    fb = 1'b0;
    n = s;
    n.tick = 1'b0;
    // Divider giving one 0.55 ms tick enable
    if (s.in_reset || s.tick_cnt == TICK_LAST)
      n.tick_cnt = 16'h0000;
    else
      n.tick_cnt = s.tick_cnt + 16'h0001;
    n.tick = !s.in_reset && s.tick_cnt == TICK_LAST;
    // Window sequencer: first window then second window
    if (s.in_reset)
    begin
      n.win_cnt = 8'h00;
      n.win2_phase = 1'b0;
    end
    else if (s.tick)
    begin
      if (!s.win2_phase && s.win_cnt == s.win1)
      begin
        n.win_cnt = 8'h00;
        n.win2_phase = 1'b1;
      end
      else if (cyc_end)
      begin
        n.win_cnt = 8'h00;
        n.win2_phase = 1'b0;
      end
      else
        n.win_cnt = s.win_cnt + 8'h01;
    end
    // End-of-cycle judgement of the tallies
    if (cyc_end)
    begin
      set_f.wrong = s.wrong_seen;
      set_f.seq = !s.mode && s.w1_answers < `WDQ_SEQ_MIN;
      set_f.timeout = s.mode ? s.cyc_answers == 3'h0 : s.cyc_answers < `WDQ_FULL_ANS;
      set_f.early = s.mode ? s.w1_answers != 3'h0 : s.w1_answers >= `WDQ_FULL_ANS;
    end
    set_f.fc_dis = fail_counter >= fail_count_threshold;
    // Tallies restart each cycle once the flags above are taken
    if (cyc_end || s.in_reset)
    begin
      n.w1_answers = 3'h0;
      n.cyc_answers = 3'h0;
      n.wrong_seen = 1'b0;
      n.answer_cnt = s.mode ? `WDQ_CNT_MODE1 : `WDQ_CNT_MODE0;
    end
    if (ans_go && !s.in_reset)
    begin
      n.answer_cnt = (cyc_end ? n.answer_cnt : s.answer_cnt) - 2'h1;
      if (cyc_end)
      begin
        n.cyc_answers = 3'h1;
        n.w1_answers = 3'h1;
      end
      else
      begin
        n.cyc_answers = s.cyc_answers == 3'h7 ? 3'h7 : s.cyc_answers + 3'h1;
        if (!s.win2_phase && s.w1_answers != 3'h7)
          n.w1_answers = s.w1_answers + 3'h1;
      end
      n.wrong_seen = (cyc_end ? 1'b0 : s.wrong_seen) || wd != expected_response;
    end
    // Question generator: seed in reset, step after a clean cycle
    fb = ^(s.lfsr & (s.qa_cfg[5:4] == 2'h0 ? `WDQ_TAPS0 : s.qa_cfg[5:4] == 2'h1 ?
      `WDQ_TAPS1 : s.qa_cfg[5:4] == 2'h2 ? `WDQ_TAPS2 : `WDQ_TAPS3));
    if (s.in_reset)
      n.lfsr = s.qa_cfg[3:0];
    else if (cyc_end && !set_f.wrong && !set_f.timeout)
    begin
      n.lfsr = {s.lfsr[2:0], fb};
      n.question = {s.lfsr[2:0], fb};
    end
    // Write channel: address and data taken together
    n.awready = awvalid && wvalid && !s.bvalid && !s.awready;
    n.wready = awvalid && wvalid && !s.bvalid && !s.awready;
    if (s.bvalid && bready)
      n.bvalid = 1'b0;
    if (wr_go)
    begin
      n.bvalid = 1'b1;
      n.bresp = `WDQ_RESP_OK;
      unique case (awaddr)
        `WDQ_A_QACFG:
          if (wstrb[0])
          begin
            n.qa_cfg = wd;
            set_f.cfg_chg = wd != s.qa_cfg;
          end
        `WDQ_A_WIN1:
          if (wstrb[0])
          begin
            n.win1 = wd;
            set_f.cfg_chg = wd != s.win1;
          end
        `WDQ_A_WIN2:
          if (wstrb[0])
          begin
            n.win2 = wd[4:0];
            set_f.cfg_chg = wd[4:0] != s.win2;
          end
        `WDQ_A_CTRL:
          if (wstrb[0])
          begin
            n.mode = wd[0];
            n.in_reset = wd[1];
            set_f.cfg_chg = wd[0] != s.mode;
            if (wd[0] != s.mode)
              n.answer_cnt = wd[0] ? `WDQ_CNT_MODE1 : `WDQ_CNT_MODE0;
          end
        `WDQ_A_IRQCLR:
          if (wstrb[0])
            irq_clr = wd[5:0];
        `WDQ_A_IRQEN:
          if (wstrb[0])
            n.irq_en = wd[5:0];
        `WDQ_A_ANSWER, `WDQ_A_QUEST, `WDQ_A_FLAGS, `WDQ_A_IRQST: ;
        default: n.bresp = `WDQ_RESP_ERR;
      endcase
    end
    // Read channel, flag register clears on read
    n.arready = arvalid && !s.rvalid && !s.arready;
    if (s.rvalid && rready)
      n.rvalid = 1'b0;
    if (rd_go)
    begin
      n.rvalid = 1'b1;
      n.rresp = `WDQ_RESP_OK;
      n.rdata = 32'h0000_0000;
      unique case (araddr)
        `WDQ_A_QACFG: n.rdata[7:0] = s.qa_cfg;
        `WDQ_A_QUEST: n.rdata[7:0] = {4'h0, s.question};
        `WDQ_A_FLAGS:
        begin
          n.rdata[7:0] = {s.flags.fc_dis, s.answer_cnt, s.flags.cfg_chg, s.flags.wrong,
            s.flags.seq, s.flags.timeout, s.flags.early};
          clr_f = '1;
        end
        `WDQ_A_WIN1: n.rdata[7:0] = s.win1;
        `WDQ_A_WIN2: n.rdata[7:0] = {3'h0, s.win2};
        `WDQ_A_CTRL: n.rdata[7:0] = {6'h00, s.in_reset, s.mode};
        `WDQ_A_IRQST: n.rdata[7:0] = {2'h0, s.irq_stat};
        `WDQ_A_IRQEN: n.rdata[7:0] = {2'h0, s.irq_en};
        `WDQ_A_ANSWER, `WDQ_A_IRQCLR: ;
        default: n.rresp = `WDQ_RESP_ERR;
      endcase
    end
    // Set wins over a clear in the same cycle
    n.flags = (s.flags & ~clr_f) | set_f;
    n.irq_stat = (s.irq_stat & ~irq_clr) | set_f;
    n.irq = |(n.irq_stat & n.irq_en);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.qa_cfg <= `WDQ_RST_QACFG;
      s.win1 <= `WDQ_RST_WIN1;
      s.win2 <= `WDQ_RST_WIN2;
      s.in_reset <= 1'b1;
      s.lfsr <= 4'(`WDQ_RST_QACFG); // Seed nibble of the reset config
      s.question <= `WDQ_RST_QUEST;
      s.answer_cnt <= `WDQ_CNT_MODE0;
      s.flags.fc_dis <= 1'b1;
    end
    else
      s <= n;
  end

  // Outputs straight from the state register
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;
  assign question_value = s.question;
  assign irq = s.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_seed;
    s.in_reset && !wr_go |=> s.lfsr == $past(s.qa_cfg[3:0]);
  endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded in reset");
  property p_question;
    !cyc_end |=> $stable(s.question);
  endproperty
  a_question: assert property (p_question) else $error("question moved mid-cycle");
  property p_fcdis;
    fail_counter >= fail_count_threshold |=> s.flags.fc_dis;
  endproperty
  a_fcdis: assert property (p_fcdis) else $error("fail-count flag missing");
  property p_cnt;
    s.in_reset && !s.mode && !wr_go |=> s.answer_cnt == 2'h3;
  endproperty
  a_cnt: assert property (p_cnt) else $error("answer counter reload wrong");
  property p_cfg;
    wr_go && wstrb[0] && awaddr == `WDQ_A_WIN1 && wd != s.win1 |=> s.flags.cfg_chg;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config change not flagged");
  property p_wrong;
    cyc_end && s.wrong_seen |=> s.flags.wrong && s.irq_stat[3];
  endproperty
  a_wrong: assert property (p_wrong) else $error("wrong answer not flagged");
  property p_seq;
    cyc_end && !s.mode && s.w1_answers < 3'h3 |=> s.flags.seq;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence flag missing");
  property p_tout;
    cyc_end && s.mode && s.cyc_answers == 3'h0 |=> s.flags.timeout;
  endproperty
  a_tout: assert property (p_tout) else $error("time-out flag missing");
  property p_early;
    cyc_end && !s.mode && s.w1_answers >= 3'h4 |=> s.flags.early;
  endproperty
  a_early: assert property (p_early) else $error("early flag missing");
  property p_win1;
    $rose(s.win2_phase) |-> $past(s.win_cnt) == $past(s.win1) && $past(s.tick);
  endproperty
  a_win1: assert property (p_win1) else $error("first window length wrong");
  property p_win2;
    $fell(s.win2_phase) && !$past(s.in_reset) |-> $past(s.win_cnt) == {3'h0, $past(s.win2)};
  endproperty
  a_win2: assert property (p_win2) else $error("second window length wrong");
  property p_tally;
    cyc_end && !ans_go |=> s.cyc_answers == 3'h0 && !s.wrong_seen;
  endproperty
  a_tally: assert property (p_tally) else $error("tallies not restarted");
endmodule
`default_nettype wire
